// >>> verilog/octal_uart_card_defines.vh
// Register map, field positions and timing constants of the serial card.
// Overview of operation
// RULE1: One I/O window; each of eight ports owns eight consecutive byte registers.
// RULE2: A shared register at offset 64 shows which ports request interrupts.
// RULE3: Line control bit 7 redirects port offsets 0 and 1 to the divisor.
// RULE4: With divisor access on, offset 0 is divisor low, offset 1 high.
// RULE5: Bit rate is reference clock divided by 16 times the divisor.
// RULE6: Each UART uses a 1.8432 MHz baud reference.
// RULE7: Divisor 0x000C in base range gives 9600 baud.
// RULE8: Line control bits 0 and 1 hold character length minus five.
// RULE9: Line control bit 2 selects one or two stop bits.
// RULE10: Line control bits 3 to 6 control parity and break.
// RULE11: Host clears divisor access after loading the divisor.
// RULE12: Writing 0x03 gives eight bits, no parity, one stop bit.
// RULE13: Line status bit 0 is high while a received character waits.
// RULE14: Interrupt identification reads 0x04 for received data available.
// RULE15: Reading offset 0 with divisor access off returns the received byte.
// RULE16: Line status bit 5 is high while the transmit holding register is empty.
// RULE17: A jumper selects base or eightfold reference range up to 921,600 baud.
// RULE18: Shared source register holds one request bit per port, bit equals port.
`ifndef OCTAL_UART_CARD_DEFINES_VH
`define OCTAL_UART_CARD_DEFINES_VH
`define OFS_DATA          3'h0
`define OFS_IRQ_ENABLE    3'h1
`define OFS_IRQ_IDENT     3'h2
`define OFS_LINE_CONTROL  3'h3
`define OFS_LINE_STATUS   3'h5
`define OFS_SOURCES       7'h40
`define LCR_LEN_LO        0
`define LCR_STOP2         2
`define LCR_PAR_EN        3
`define LCR_PAR_EVEN      4
`define LCR_PAR_STICK     5
`define LCR_BREAK         6
`define LCR_DIV_ACCESS    7
`define LSR_DATA_READY    0
`define LSR_OVERRUN       1
`define LSR_PARITY_ERR    2
`define LSR_FRAMING_ERR   3
`define LSR_THR_EMPTY     5
`define LSR_TX_IDLE       6
`define IIR_NONE          8'h01
`define IIR_THR_EMPTY     8'h02
`define IIR_RX_DATA       8'h04
`define LCR_RESET         8'h03
`define DIVISOR_RESET     16'h000C
`define REF_HZ            1843200
`define REF_EDGE_HZ       (2 * `REF_HZ)
`define OVERSAMPLE        32
`define SAMPLE_POINT      5'h0F
`define LAST_SAMPLE       5'h1F
`endif

// >>> verilog/octal_uart_card.v
// Eight-port UART card core with its byte-wide I/O register window.
`timescale 1ns/1ps
`include "octal_uart_card_defines.vh"
module octal_uart_card #(
  parameter CLK_HZ    = 125000000,
  parameter QUAD_MULT = 8
)
(
  input  wire       clk,        // System clock, 125 MHz.
  input  wire       sys_rst,    // Synchronous reset, active high.
  input  wire [6:0] io_addr,    // Byte offset inside the I/O window.
  input  wire       io_rd,      // One-cycle read strobe.
  input  wire       io_wr,      // One-cycle write strobe.
  input  wire [7:0] io_wdata,   // Write data.
  input  wire       range_x4,   // Reference range jumper, high for fast.
  input  wire [7:0] rxd,        // Serial receive lines, one per port.
  output reg  [7:0] io_rdata,   // Read data, valid the cycle after io_rd.
  output reg  [7:0] txd,        // Serial transmit lines, one per port.
  output reg  [7:0] port_irq,   // Per-port interrupt requests.
  output reg        card_irq    // Any port requesting.
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA  = 3'h2;
  localparam ST_PAR   = 3'h3;
  localparam ST_STOP  = 3'h4;
  localparam [15:0] DIV_RST = `DIVISOR_RESET;

  // Parity bit for the character, honouring even and stick selections.
  function par_bit;
    input [7:0] data;
    input [7:0] lcr;
    begin
      if (lcr[`LCR_PAR_STICK])
        par_bit = ~lcr[`LCR_PAR_EVEN];
      else
        par_bit = (^data) ^ ~lcr[`LCR_PAR_EVEN];
    end
  endfunction

  reg        range_s1;
  reg        range_s2;
  reg  [7:0] rx_s1;
  reg  [7:0] rx_s2;
  reg [31:0] ref_acc;
  reg        edge_tick;
  wire [31:0] ref_step;
  wire [32:0] ref_sum;
  wire        hit_port;
  wire [2:0]  port_sel;
  wire [2:0]  ofs;
  wire [63:0] port_val;
  wire [7:0]  irq_w;
  wire [7:0]  tx_w;

  // Jumper and serial inputs are asynchronous to clk.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      range_s1 <= 1'b0;
      range_s2 <= 1'b0;
      rx_s1    <= 8'hFF;
      rx_s2    <= 8'hFF;
    end
    else
    begin
      range_s1 <= range_x4;
      range_s2 <= range_s1;
      rx_s1    <= rxd;
      rx_s2    <= rx_s1;
    end
  end

  // Fractional synthesis of both edges of the baud reference; the jitter
  // is one system clock, far below a bit time even at the top rate.
  assign ref_step = range_s2 ? `REF_EDGE_HZ * QUAD_MULT : `REF_EDGE_HZ; //RULE17
  assign ref_sum  = {1'b0, ref_acc} + {1'b0, ref_step};

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ref_acc   <= 32'h00000000;
      edge_tick <= 1'b0;
    end
    else if (ref_sum >= CLK_HZ) //RULE6
    begin
      ref_acc   <= ref_sum[31:0] - CLK_HZ[31:0];
      edge_tick <= 1'b1;
    end
    else
    begin
      ref_acc   <= ref_sum[31:0];
      edge_tick <= 1'b0;
    end
  end

  assign hit_port = ~io_addr[6]; //RULE1
  assign port_sel = io_addr[5:3];
  assign ofs      = io_addr[2:0];

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : port
      reg  [7:0] lcr;
      reg  [7:0] dll;
      reg  [7:0] dlm;
      reg  [1:0] ier;
      reg  [7:0] thr;
      reg        thr_full;
      reg  [7:0] rbr;
      reg        dr;
      reg        oe;
      reg        pe;
      reg        fe;
      reg [15:0] bcnt;
      reg        os_tick;
      reg  [2:0] tx_st;
      reg  [4:0] tx_os;
      reg  [2:0] tx_bit;
      reg  [7:0] tx_sh;
      reg        tx_par;
      reg        tx_line;
      reg  [2:0] rx_st;
      reg  [4:0] rx_os;
      reg  [2:0] rx_bit;
      reg  [7:0] rx_sh;
      reg  [7:0] rd_val;
      wire       sel;
      wire       divisor_access_select;
      wire       wr;
      wire       rd;
      wire [15:0] dv;
      wire [2:0] last_bit;
      wire       rx;
      wire       rx_store;
      wire       tx_load;

      assign sel      = hit_port && (port_sel == i);
      assign divisor_access_select     = lcr[`LCR_DIV_ACCESS]; //RULE3
      assign wr       = io_wr && sel;
      assign rd       = io_rd && sel;
      assign dv       = {dlm, dll};
      assign last_bit = {1'b0, lcr[1:0]} + 3'h4; //RULE8
      assign rx       = rx_s2[i];
      assign rx_store = os_tick && (rx_st == ST_STOP) &&
                        (rx_os == `SAMPLE_POINT);
      assign tx_load  = (tx_st == ST_IDLE) && thr_full && !wr;

      // Host-visible registers and their side effects.
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          lcr      <= `LCR_RESET;
          dll      <= DIV_RST[7:0];
          dlm      <= DIV_RST[15:8];
          ier      <= 2'b00;
          thr      <= 8'h00;
          thr_full <= 1'b0;
        end
        else
        begin
          if (wr && ofs == `OFS_DATA && divisor_access_select)
            dll <= io_wdata; //RULE4 RULE7
          if (wr && ofs == `OFS_IRQ_ENABLE && divisor_access_select)
            dlm <= io_wdata; //RULE4
          if (wr && ofs == `OFS_IRQ_ENABLE && !divisor_access_select)
            ier <= io_wdata[1:0];
          if (wr && ofs == `OFS_LINE_CONTROL)
            lcr <= io_wdata; //RULE12
          if (wr && ofs == `OFS_DATA && !divisor_access_select)
          begin
            thr      <= io_wdata;
            thr_full <= 1'b1; //RULE16
          end
          else if (tx_load)
            thr_full <= 1'b0;
        end
      end

      // Receive flags: a new character wins over a clearing read.
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          rbr <= 8'h00;
          dr  <= 1'b0;
          oe  <= 1'b0;
          pe  <= 1'b0;
          fe  <= 1'b0;
        end
        else if (rx_store)
        begin
          rbr <= rx_sh >> (2'h3 - lcr[1:0]);
          dr  <= 1'b1; //RULE13
          oe  <= dr && !(rd && ofs == `OFS_DATA && !divisor_access_select);
          fe  <= !rx;
        end
        else
        begin
          if (rd && ofs == `OFS_DATA && !divisor_access_select)
            dr <= 1'b0; //RULE15
          if (rd && ofs == `OFS_LINE_STATUS)
          begin
            oe <= 1'b0;
            pe <= 1'b0;
            fe <= 1'b0;
          end
          if (os_tick && rx_st == ST_PAR && rx_os == `SAMPLE_POINT &&
              rx != par_bit(rx_sh >> (2'h3 - lcr[1:0]), lcr))
            pe <= 1'b1; //RULE10
        end
      end

      // Each oversample tick is divisor reference edges; a bit spans 32.
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          bcnt    <= 16'h0000;
          os_tick <= 1'b0;
        end
        else if (edge_tick && (bcnt + 16'h0001 >= dv)) //RULE5
        begin
          bcnt    <= 16'h0000;
          os_tick <= 1'b1;
        end
        else
        begin
          if (edge_tick)
            bcnt <= bcnt + 16'h0001;
          os_tick <= 1'b0;
        end
      end

      // Transmitter.
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          tx_st   <= ST_IDLE;
          tx_os   <= 5'h00;
          tx_bit  <= 3'h0;
          tx_sh   <= 8'h00;
          tx_par  <= 1'b0;
          tx_line <= 1'b1;
        end
        else
        begin
          case (tx_st)
            ST_IDLE:
            begin
              tx_line <= 1'b1;
              if (tx_load)
              begin
                tx_sh   <= thr;
                tx_par  <= par_bit(thr, lcr);
                tx_os   <= 5'h00;
                tx_st   <= ST_START;
                tx_line <= 1'b0;
              end
            end
            default:
            begin
              if (os_tick)
              begin
                tx_os <= tx_os + 5'h01;
                if (tx_os == `LAST_SAMPLE)
                begin
                  case (tx_st)
                    ST_START:
                    begin
                      tx_st   <= ST_DATA;
                      tx_bit  <= 3'h0;
                      tx_line <= tx_sh[0];
                    end
                    ST_DATA:
                    begin
                      tx_bit <= tx_bit + 3'h1;
                      tx_sh  <= tx_sh >> 1;
                      if (tx_bit == last_bit)
                      begin
                        tx_st   <= lcr[`LCR_PAR_EN] ? ST_PAR : ST_STOP;
                        tx_line <= lcr[`LCR_PAR_EN] ? tx_par : 1'b1;
                        tx_bit  <= 3'h0;
                      end
                      else
                        tx_line <= tx_sh[1];
                    end
                    ST_PAR:
                    begin
                      tx_st   <= ST_STOP;
                      tx_line <= 1'b1;
                    end
                    default:
                    begin
                      tx_bit <= tx_bit + 3'h1;
                      if (tx_bit == {2'b00, lcr[`LCR_STOP2]}) //RULE9
                        tx_st <= ST_IDLE;
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end

      // Receiver samples at the middle of each 32-tick bit.
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          rx_st  <= ST_IDLE;
          rx_os  <= 5'h00;
          rx_bit <= 3'h0;
          rx_sh  <= 8'h00;
        end
        else if (rx_st == ST_IDLE)
        begin
          rx_os <= 5'h00;
          if (!rx)
            rx_st <= ST_START;
        end
        else if (os_tick)
        begin
          rx_os <= rx_os + 5'h01;
          if (rx_os == `SAMPLE_POINT)
          begin
            case (rx_st)
              ST_START:
                if (rx)
                  rx_st <= ST_IDLE;
              ST_DATA:
                rx_sh <= {rx, rx_sh[7:1]};
              ST_STOP:
                rx_st <= ST_IDLE;
              default:
                rx_st <= rx_st;
            endcase
          end
          else if (rx_os == `LAST_SAMPLE)
          begin
            case (rx_st)
              ST_START:
              begin
                rx_st  <= ST_DATA;
                rx_bit <= 3'h0;
              end
              ST_DATA:
              begin
                rx_bit <= rx_bit + 3'h1;
                if (rx_bit == last_bit)
                  rx_st <= lcr[`LCR_PAR_EN] ? ST_PAR : ST_STOP;
              end
              default:
                rx_st <= ST_STOP;
            endcase
          end
        end
      end

      always @*
      begin
        case (ofs)
          `OFS_DATA:         rd_val = divisor_access_select ? dll : rbr;
          `OFS_IRQ_ENABLE:   rd_val = divisor_access_select ? dlm : {6'h00, ier};
          `OFS_IRQ_IDENT:
            if (dr && ier[0])
              rd_val = `IIR_RX_DATA; //RULE14
            else if (!thr_full && ier[1])
              rd_val = `IIR_THR_EMPTY;
            else
              rd_val = `IIR_NONE;
          `OFS_LINE_CONTROL: rd_val = lcr;
          `OFS_LINE_STATUS:
            rd_val = {1'b0, !thr_full && tx_st == ST_IDLE, !thr_full,
                      1'b0, fe, pe, oe, dr};
          default:           rd_val = 8'h00;
        endcase
      end

      assign port_val[8*i +: 8] = rd_val;
      assign irq_w[i] = (dr && ier[0]) || (!thr_full && ier[1]);
      assign tx_w[i]  = tx_line && !lcr[`LCR_BREAK];
    end
  endgenerate

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      io_rdata <= 8'h00;
      txd      <= 8'hFF;
      port_irq <= 8'h00;
      card_irq <= 1'b0;
    end
    else
    begin
      txd      <= tx_w;
      port_irq <= irq_w; //RULE18
      card_irq <= |irq_w;
      if (io_rd)
      begin
        if (hit_port)
          io_rdata <= port_val[8*port_sel +: 8];
        else if (io_addr == `OFS_SOURCES)
          io_rdata <= port_irq; //RULE2
        else
          io_rdata <= 8'h00;
      end
    end
  end

endmodule

// >>> verification/octal_uart_card_props.sv
// Port-level assertions for the eight-port serial card core.
`timescale 1ns/1ps
module octal_uart_card_props (
  input wire logic       clk,      // System clock.
  input wire logic       sys_rst,  // Synchronous reset.
  input wire logic [6:0] io_addr,  // Register offset.
  input wire logic       io_rd,    // Read strobe.
  input wire logic [7:0] io_rdata, // Read data.
  input wire logic [7:0] txd,      // Serial outputs.
  input wire logic [7:0] port_irq, // Port requests.
  input wire logic       card_irq  // Any request.
);
  wire       prt = (io_addr < 7'h40);
  wire [2:0] ofs = io_addr[2:0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_reset_state: assert property (disable iff (1'b0) sys_rst |=>
    io_rdata == 8'h00 && txd == 8'hFF && port_irq == 8'h00 && !card_irq)
    else $error("Outputs left reset state.");
  a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("Read data moved without a read.");
  a_unmapped_zero: assert property (io_rd && (io_addr > 7'h40 ||
    (prt && (ofs == 3'h4 || ofs > 3'h5))) |=> io_rdata == 8'h00)
    else $error("Unmapped offset read nonzero.");
  a_sources_read: assert property (io_rd && io_addr == 7'h40
    |=> io_rdata == $past(port_irq))
    else $error("Source register differs from requests.");
  a_ident_codes: assert property (io_rd && prt && ofs == 3'h2
    |=> io_rdata inside {8'h01, 8'h02, 8'h04})
    else $error("Bad identification code.");
  a_status_form: assert property (io_rd && prt && ofs == 3'h5
    |=> !io_rdata[7] && !io_rdata[4] && (!io_rdata[6] || io_rdata[5]))
    else $error("Bad line status form.");
  a_card_on: assert property ((|port_irq) |-> ##[0:1] card_irq)
    else $error("Card request missing.");
  a_card_off: assert property (port_irq == 8'h00 |-> ##[0:1] !card_irq)
    else $error("Card request without port request.");
endmodule

bind octal_uart_card octal_uart_card_props i_octal_uart_card_props (
  .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd),
  .io_rdata(io_rdata), .txd(txd), .port_irq(port_irq),
  .card_irq(card_irq));

// >>> verification/serial_far_end.sv
// Far-end serial terminal model for the card's eight lines.
`timescale 1ns/1ps
module serial_far_end #(
  parameter real BIT_NS = 1085.07
)
(
  input  wire [7:0] txd, // Card transmit lines.
  output reg  [7:0] rxd  // Card receive lines, idle high.
);
  integer i;
  initial rxd = 8'hFF;
  // Start, eight data bits from the bottom up, one stop bit.
  task send(input integer p, input [7:0] b);
    begin
      rxd[p] = 1'b0;
      #(BIT_NS);
      for (i = 0; i < 8; i = i + 1)
      begin
        rxd[p] = b[i];
        #(BIT_NS);
      end
      rxd[p] = 1'b1;
      #(BIT_NS);
    end
  endtask
  // Samples mid-bit; ok is low on a missing start or stop bit.
  task recv(input integer p, input integer n, output [7:0] b,
            output ok);
    begin
      b = 8'h00;
      for (i = 0; i < 4000 && txd[p]; i = i + 1)
        #8;
      #(BIT_NS / 2);
      ok = !txd[p];
      for (i = 0; i < n; i = i + 1)
      begin
        #(BIT_NS);
        b[i] = txd[p];
      end
      #(BIT_NS);
      ok = ok & txd[p];
    end
  endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the eight-port serial card core.
`timescale 1ns/1ps
module tb;
  reg        clk = 1'b0;
  reg        sys_rst = 1'b1;
  reg  [6:0] io_addr = 7'h00;
  reg        io_rd = 1'b0;
  reg        io_wr = 1'b0;
  reg  [7:0] io_wdata = 8'h00;
  reg        range_x4 = 1'b0;
  wire [7:0] rxd;
  wire [7:0] txd;
  wire [7:0] port_irq;
  wire [7:0] io_rdata;
  wire       card_irq;
  reg  [7:0] d;
  reg        ok;
  integer    num_errors = 0;
  integer    total_checks = 0;
  integer    n;
  initial forever #4 clk = ~clk;
  octal_uart_card i_octal_uart_card (.clk(clk), .sys_rst(sys_rst),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .range_x4(range_x4), .rxd(rxd),
    .io_rdata(io_rdata), .txd(txd), .port_irq(port_irq),
    .card_irq(card_irq));
  serial_far_end i_serial_far_end (.txd(txd), .rxd(rxd));

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_rng(input integer got, input integer lo, input integer hi);
    begin
      total_checks = total_checks + 1;
      if (got < lo || got > hi)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, lo);
      end
    end
  endtask
  function [6:0] ad(input [2:0] p, input [2:0] r);
    ad = {1'b0, p, r};
  endfunction
  task wr(input [6:0] a, input [7:0] v);
    begin
      @(negedge clk);
      io_addr = a;
      io_wdata = v;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
    end
  endtask
  task rd(input [6:0] a);
    begin
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      d = io_rdata;
    end
  endtask
  task wait_lsr(input [2:0] p, input [7:0] m);
    begin
      d = 8'h00;
      for (n = 0; n < 300 && (d & m) == 8'h00; n = n + 1)
        rd(ad(p, 3'h5));
      if ((d & m) == 8'h00)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, d, m);
        tally_and_finish;
      end
    end
  endtask
  task setup(input [2:0] p, input [7:0] dv);
    begin
      wr(ad(p, 3'h3), 8'h80);
      wr(ad(p, 3'h0), dv);
      wr(ad(p, 3'h1), 8'h00);
      rd(ad(p, 3'h0)); chk(d, dv);
      rd(ad(p, 3'h1)); chk(d, 8'h00);
      wr(ad(p, 3'h3), 8'h03);
      rd(ad(p, 3'h3)); chk(d, 8'h03);
    end
  endtask

  task t_reset;
    begin
      rd(7'h05); chk(d, 8'h60);
      rd(7'h02); chk(d, 8'h01);
      rd(7'h40); chk(d, 8'h00);
      rd(7'h3F); chk(d, 8'h00);
      rd(7'h44); chk(d, 8'h00);
      wr(7'h3B, 8'h1B);
      rd(7'h3B); chk(d, 8'h1B);
      rd(7'h03); chk(d, 8'h03);
      $display("t_reset done");
    end
  endtask
  // Base range, divisor 12: one bit lasts 125 MHz / 9600 clocks.
  // The start bit may begin mid-tick, so the first data bit is timed.
  task t_slow;
    begin
      setup(3'h0, 8'h0C);
      wait_lsr(3'h0, 8'h20);
      wr(ad(3'h0, 3'h0), 8'h01);
      for (n = 0; n < 100 && txd[0]; n = n + 1)
        @(negedge clk);
      for (n = 0; n < 20000 && !txd[0]; n = n + 1)
        @(negedge clk);
      for (n = 0; n < 20000 && txd[0]; n = n + 1)
        @(negedge clk);
      chk_rng(n, 12890, 13150);
      // Reset cuts the slow frame short instead of waiting it out.
      sys_rst = 1'b1;
      range_x4 = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      chk(txd, 8'hFF);
      $display("t_slow done");
    end
  endtask
  task t_tx;
    begin
      setup(3'h2, 8'h01);
      wait_lsr(3'h2, 8'h20);
      wr(ad(3'h2, 3'h0), 8'hA5);
      i_serial_far_end.recv(2, 8, d, ok);
      chk(d, 8'hA5);
      chk({7'h00, ok}, 8'h01);
      wait_lsr(3'h2, 8'h40);
      wr(ad(3'h2, 3'h3), 8'h00);
      wr(ad(3'h2, 3'h0), 8'h0E);
      i_serial_far_end.recv(2, 5, d, ok);
      chk(d, 8'h0E);
      chk({7'h00, ok}, 8'h01);
      $display("t_tx done");
    end
  endtask
  task t_rx;
    begin
      setup(3'h5, 8'h01);
      wr(ad(3'h5, 3'h1), 8'h01);
      rd(ad(3'h5, 3'h2)); chk(d, 8'h01);
      i_serial_far_end.send(5, 8'h3C);
      wait_lsr(3'h5, 8'h01);
      rd(ad(3'h5, 3'h2)); chk(d, 8'h04);
      rd(7'h40); chk(d, 8'h20);
      chk({7'h00, card_irq}, 8'h01);
      rd(ad(3'h5, 3'h0)); chk(d, 8'h3C);
      rd(ad(3'h5, 3'h5)); chk(d & 8'h01, 8'h00);
      rd(7'h40); chk(d, 8'h00);
      $display("t_rx done");
    end
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
    t_slow;
    t_tx;
    t_rx;
    tally_and_finish;
  end
endmodule
